// *** gpb_pkg.sv ***
// shared constants for the port b / port c gpio block
package gpb_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  // register offsets, low eight address bits (bit 8 is a bank mirror)
  localparam logic [7:0] OFF_PORT_B_DATA = 8'h06;
  localparam logic [7:0] OFF_PORT_C_DATA = 8'h07;
  localparam logic [7:0] OFF_INT_CTRL    = 8'h0C;
  localparam logic [7:0] OFF_OPTION      = 8'h81;
  localparam logic [7:0] OFF_PORT_B_DIR  = 8'h86;
  localparam logic [7:0] OFF_PORT_C_DIR  = 8'h87;
  localparam logic [7:0] OFF_CONV_CFG    = 8'h9F;

  // registers that exist only in the lower bank
  localparam logic [0:0] BANK_LOW = 1'h0;

  // values after reset
  localparam logic [7:0] RST_OPTION   = 8'hFF;
  localparam logic [7:0] RST_DIR      = 8'hFF;
  localparam logic [7:0] RST_CONV_CFG = 8'h00;
  localparam logic [7:0] RST_LATCH    = 8'h00;
  localparam logic [7:0] RST_ZERO     = 8'h00;

  // field positions
  localparam int unsigned POS_PULLUP_N   = 7;
  localparam int unsigned POS_CHANGE_FLG = 0;
  localparam int unsigned POS_EXT_INT    = 0;
  localparam int unsigned POS_SLAVE_SEL  = 1;
  localparam int unsigned POS_AN_EIGHT   = 2;
  localparam int unsigned POS_AN_NINE    = 3;
  localparam int unsigned POS_PROG_CLK   = 6;
  localparam int unsigned POS_PROG_DATA  = 7;
  localparam int unsigned POS_CHG_LO     = 4;
  localparam int unsigned POS_CHG_HI     = 7;

  // port configuration field of converter_config_one
  localparam int unsigned POS_PCFG_LO = 0;
  localparam int unsigned POS_PCFG_HI = 3;
  // pcfg codes below this limit turn pins 2 and 3 into analog inputs
  localparam logic [3:0] PCFG_ANALOG_B_LIMIT = 4'h2;

endpackage

// *** gpb_pin_cell.sv ***
// per-pin output driver with direction override and registered outputs
`timescale 1ns/1ps
module gpb_pin_cell #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // software side
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  // override side, dir 1 means input
  input  wire logic [W-1:0] ovr_en,
  input  wire logic [W-1:0] ovr_dir,
  input  wire logic [W-1:0] ovr_out,
  // pin side
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] eff_dir
);

  logic [W-1:0] dir_d;
  logic [W-1:0] out_d;
  logic [W-1:0] out_q;
  logic [W-1:0] oe_n_q;

  // an enabled override owns both direction and driven value
  assign dir_d = (ovr_en & ovr_dir) | (~ovr_en & dir);
  assign out_d = (ovr_en & ovr_out) | (~ovr_en & latch);

  // direction 1 lets go of the pin, 0 drives the latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_q  <= '0;
      oe_n_q <= '1;
    end else begin
      out_q  <= out_d;
      oe_n_q <= dir_d;
    end
  end

  assign pin_out  = out_q;
  assign pin_oe_n = oe_n_q;
  // combinational view for the owner's gating logic
  assign eff_dir  = dir_d;

endmodule

// *** gpb_ports.sv ***
// port b and port c general purpose io with change detect on b<7:4>
`timescale 1ns/1ps
// How it works
// [RULE1] pullup_enable_n low in option_config turns on all port b pull-ups
// [RULE2] a port b pin set as output never gets its pull-up
// [RULE3] option_config resets to all ones, so pull-ups start off
// [RULE4] only upper port b pins set as inputs take part in change detect
// [RULE5] each such pin is compared with its level at the last port b read
// [RULE6] per-pin mismatches are ored and set port_change_flag, bit 0
// [RULE7] a set port_change_flag raises the wake request out of sleep
// [RULE8] any port b data read or write refreshes the snapshot
// [RULE9] a lasting mismatch keeps setting the flag despite software clears
// [RULE10] software should not poll port b while waiting on the change flag
// [RULE11] port c direction 1 floats the pin, 0 drives its output latch
// [RULE12] an enabled peripheral overrides the port c pin direction
// [RULE13] no bit read-modify-write on port c direction during overrides
// [RULE14] port c pins carry timer, capture, serial and usart functions
// [RULE15] port b pin 0 feeds the external interrupt input
// [RULE16] port b pin 1 feeds the serial module slave select
// [RULE17] port b pin 2 doubles as analog channel eight
// [RULE18] port b pin 3 doubles as analog nine and low voltage detect
// [RULE19] in programming mode pin 6 is the clock and pin 7 the data
// [RULE20] port b direction 1 floats the pin, 0 drives its output latch
// [RULE21] data reads give pin levels, writes load the output latch
// [RULE22] snapshot is taken in the very cycle of the port b access
module gpb_ports
  import gpb_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // port b pins
  input  wire logic [7:0]        pb_in,
  output logic      [7:0]        pb_out,
  output logic      [7:0]        pb_oe_n,
  output logic      [7:0]        pb_pullup_en,
  // port c pins
  input  wire logic [7:0]        pc_in,
  output logic      [7:0]        pc_out,
  output logic      [7:0]        pc_oe_n,
  // port c peripheral overrides, dir 1 forces input
  input  wire logic [7:0]        periph_en,
  input  wire logic [7:0]        periph_dir,
  input  wire logic [7:0]        periph_dout,
  output logic      [7:0]        periph_din,
  // port b alternate functions
  output logic                   ext_int_in,
  output logic                   ssp_slave_sel_n,
  output logic                   analog_channel_eight_sel,
  output logic                   analog_channel_nine_sel,
  output logic                   low_voltage_detect_input,
  // serial programming
  input  wire logic              prog_mode,
  input  wire logic              prog_data_out,
  input  wire logic              prog_data_drive,
  output logic                   prog_clk,
  output logic                   prog_data_in,
  // change interrupt
  output logic                   port_change_flag,
  output logic                   wake_req
);

  // software registers
  logic [7:0] port_b_latch_q;
  logic [7:0] port_c_latch_q;
  logic [7:0] port_b_direction_q;
  logic [7:0] port_c_direction_q;
  logic [7:0] option_config_q;
  logic [7:0] converter_config_one_q;

  // change detect state
  logic [3:0] snap_q;
  logic       flag_q;
  logic       flag_d;

  // read path
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // registered alternate-function and status outputs
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] periph_din_q;
  logic       ext_int_q;
  logic       slave_sel_n_q;
  logic       an_eight_q;
  logic       an_nine_q;
  logic       lvd_q;
  logic       prog_clk_q;
  logic       prog_data_in_q;
  logic       wake_q;

  // address decode
  logic [7:0] addr_lo;
  logic       bank_low;
  logic       sel_pb;
  logic       sel_pc;
  logic       sel_int;
  logic       sel_opt;
  logic       sel_pbdir;
  logic       sel_pcdir;
  logic       sel_conv;
  logic       pb_access;

  // derived port b state
  logic [7:0] pb_eff_dir;
  logic [7:0] pb_ovr_en;
  logic [7:0] pb_ovr_dir;
  logic [7:0] pb_ovr_out;
  logic [7:0] pb_read;
  logic [3:0] chg_inputs;
  logic [3:0] mismatch;
  logic       change_any;
  logic       analog_b;
  logic [3:0] pcfg;

  // port c direction after peripheral override
  logic [7:0] pc_eff_dir;

  // mirrored registers ignore address bit 8; the rest live in bank low
  assign addr_lo   = reg_addr[7:0];
  assign bank_low  = (reg_addr[ADDR_W-1] == BANK_LOW);
  assign sel_pb    = (addr_lo == OFF_PORT_B_DATA);
  assign sel_pc    = (addr_lo == OFF_PORT_C_DATA) && bank_low;
  assign sel_int   = (addr_lo == OFF_INT_CTRL);
  assign sel_opt   = (addr_lo == OFF_OPTION);
  assign sel_pbdir = (addr_lo == OFF_PORT_B_DIR);
  assign sel_pcdir = (addr_lo == OFF_PORT_C_DIR) && bank_low;
  assign sel_conv  = (addr_lo == OFF_CONV_CFG) && bank_low;
  assign pb_access = sel_pb && (reg_rd || reg_wr); // RULE8

  // analog selection of pins 2 and 3 from the port configuration field
  assign pcfg     = converter_config_one_q[POS_PCFG_HI:POS_PCFG_LO];
  assign analog_b = (pcfg < PCFG_ANALOG_B_LIMIT);

  // pins in analog mode read back as zero; others give the pin level
  assign pb_read = analog_b ?
                   (pb_in & ~(8'h01 << POS_AN_EIGHT)
                          & ~(8'h01 << POS_AN_NINE)) :
                   pb_in; // RULE21

  // programming mode takes pin 6 as input and lends pin 7 to the loader
  assign pb_ovr_en  = prog_mode ?
                      ((8'h01 << POS_PROG_CLK) | (8'h01 << POS_PROG_DATA)) :
                      8'h00; // RULE19
  assign pb_ovr_dir = (8'h01 << POS_PROG_CLK) |
                      (prog_data_drive ? 8'h00 :
                       (8'h01 << POS_PROG_DATA));
  assign pb_ovr_out = prog_data_out ? (8'h01 << POS_PROG_DATA) : 8'h00;

  // only upper pins that are inputs join the comparison
  assign chg_inputs = pb_eff_dir[POS_CHG_HI:POS_CHG_LO]; // RULE4
  assign mismatch   = (pb_in[POS_CHG_HI:POS_CHG_LO] ^ snap_q)
                      & chg_inputs; // RULE5
  assign change_any = |mismatch; // RULE6

  // set beats the software clear, so a held mismatch re-sets the flag
  assign flag_d = change_any ||
                  (flag_q && !(reg_wr && sel_int &&
                               !reg_wdata[POS_CHANGE_FLG])); // RULE9

  // pull-ups on input pins only, gated by the active-low global enable
  assign pullup_d = option_config_q[POS_PULLUP_N] ? 8'h00 :
                    pb_eff_dir; // RULE1 RULE2

  // software registers; reset leaves pull-ups off and all pins input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_latch_q         <= RST_LATCH;
      port_c_latch_q         <= RST_LATCH;
      port_b_direction_q     <= RST_DIR;
      port_c_direction_q     <= RST_DIR;
      option_config_q        <= RST_OPTION; // RULE3
      converter_config_one_q <= RST_CONV_CFG;
    end else if (reg_wr) begin
      if (sel_pb) port_b_latch_q <= reg_wdata; // RULE21
      if (sel_pc) port_c_latch_q <= reg_wdata;
      if (sel_pbdir) port_b_direction_q <= reg_wdata;
      if (sel_pcdir) port_c_direction_q <= reg_wdata;
      if (sel_opt) option_config_q <= reg_wdata;
      if (sel_conv) converter_config_one_q <= reg_wdata;
    end
  end

  // snapshot follows the pins in the same cycle as the access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= 4'h0;
    end else if (pb_access) begin
      snap_q <= pb_in[POS_CHG_HI:POS_CHG_LO]; // RULE22 RULE8
    end
  end

  // change flag and the wake request derived from it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      flag_q <= flag_d; // RULE6
      wake_q <= flag_d; // RULE7
    end
  end

  // port b driver: direction 1 floats, 0 drives the latch
  gpb_pin_cell #(
    .W (8)
  ) u_port_b (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .latch    (port_b_latch_q),
    .dir      (port_b_direction_q),
    .ovr_en   (pb_ovr_en),
    .ovr_dir  (pb_ovr_dir),
    .ovr_out  (pb_ovr_out),
    .pin_out  (pb_out),
    .pin_oe_n (pb_oe_n),
    .eff_dir  (pb_eff_dir)
  ); // RULE20

  // port c driver: enabled peripherals own direction and value
  gpb_pin_cell #(
    .W (8)
  ) u_port_c (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .latch    (port_c_latch_q),
    .dir      (port_c_direction_q),
    .ovr_en   (periph_en),
    .ovr_dir  (periph_dir),
    .ovr_out  (periph_dout),
    .pin_out  (pc_out),
    .pin_oe_n (pc_oe_n),
    .eff_dir  (pc_eff_dir)
  ); // RULE11 RULE12

  // alternate-function inputs, registered so every output is a flop
  // the input buffers are digital; hysteresis is left to the pad
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_q       <= RST_ZERO;
      periph_din_q   <= RST_ZERO;
      ext_int_q      <= 1'b0;
      slave_sel_n_q  <= 1'b1;
      an_eight_q     <= 1'b0;
      an_nine_q      <= 1'b0;
      lvd_q          <= 1'b0;
      prog_clk_q     <= 1'b0;
      prog_data_in_q <= 1'b0;
    end else begin
      pullup_q       <= pullup_d;
      periph_din_q   <= pc_in; // RULE14
      ext_int_q      <= pb_in[POS_EXT_INT]; // RULE15
      slave_sel_n_q  <= pb_in[POS_SLAVE_SEL]; // RULE16
      an_eight_q     <= analog_b; // RULE17
      an_nine_q      <= analog_b; // RULE18
      lvd_q          <= pb_in[POS_AN_NINE]; // RULE18
      prog_clk_q     <= prog_mode && pb_in[POS_PROG_CLK]; // RULE19
      prog_data_in_q <= prog_mode && pb_in[POS_PROG_DATA];
    end
  end

  // read mux; port reads return pin levels, unmapped reads return zero
  always_comb begin
    rdata_d = RST_ZERO;
    if (sel_pb) begin
      rdata_d = pb_read; // RULE21
    end else if (sel_pc) begin
      rdata_d = pc_in;
    end else if (sel_int) begin
      rdata_d = {7'h00, flag_q};
    end else if (sel_opt) begin
      rdata_d = option_config_q;
    end else if (sel_pbdir) begin
      rdata_d = port_b_direction_q;
    end else if (sel_pcdir) begin
      rdata_d = port_c_direction_q;
    end else if (sel_conv) begin
      rdata_d = converter_config_one_q;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= RST_ZERO;
    end
  end

  // outputs
  assign reg_rdata                = rdata_q;
  assign pb_pullup_en             = pullup_q;
  assign periph_din               = periph_din_q;
  assign ext_int_in               = ext_int_q;
  assign ssp_slave_sel_n          = slave_sel_n_q;
  assign analog_channel_eight_sel = an_eight_q;
  assign analog_channel_nine_sel  = an_nine_q;
  assign low_voltage_detect_input = lvd_q;
  assign prog_clk                 = prog_clk_q;
  assign prog_data_in             = prog_data_in_q;
  assign port_change_flag         = flag_q;
  assign wake_req                 = wake_q;

  // the software-side usage notes need no hardware:
  // polling port b hides changes, and bit operations on port c
  // direction under override read back port_c_direction_q, never the forced values (RULE10 RULE13)

endmodule

// *** gpb_ports_assertions.sv ***
// concurrent checks on the port b / port c gpio block ports
`timescale 1ns/1ps
module gpb_ports_chk
  import gpb_pkg::*;
(
  // clock, reset and register port
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and overrides
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pb_oe_n,
  input wire logic [7:0] pb_pullup_en,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  input wire logic [7:0] periph_en,
  input wire logic [7:0] periph_dir,
  input wire logic [7:0] periph_dout,
  // alternate functions and change flag
  input wire logic       ext_int_in,
  input wire logic       ssp_slave_sel_n,
  input wire logic       prog_mode,
  input wire logic       prog_clk,
  input wire logic       port_change_flag,
  input wire logic       wake_req
);
  logic [3:0] snap_q;
  wire        acc  = (reg_rd | reg_wr) && reg_addr[7:0] == OFF_PORT_B_DATA;
  wire [3:0]  diff = pb_in[7:4] ^ snap_q;
  wire        mm   = |(diff & pb_oe_n[7:4]);
  // shadow snapshot; direction seen through the pin register, one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      snap_q <= 4'h0;
    else if (acc)
      snap_q <= pb_in[7:4];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  rd_pins_a:
    assert property (reg_rd && reg_addr[7:0] == OFF_PORT_B_DATA |=>
      reg_rdata[7:4] == $past(pb_in[7:4])) else $error("port b read");
  pull_out_a:
    assert property ((pb_pullup_en & ~pb_oe_n) == 8'h00)
    else $error("pull-up on driven pin");
  pull_rst_a:
    assert property ($rose(rst_n) |-> pb_pullup_en == 8'h00)
    else $error("pull-up after reset");
  chg_set_a:
    assert property (mm |=> port_change_flag || $changed(pb_oe_n))
    else $error("change flag not set");
  chg_src_a:
    assert property ($rose(port_change_flag) |-> $past(diff) != 4'h0)
    else $error("change flag without mismatch");
  chg_clr_a:
    assert property (reg_wr && reg_addr[7:0] == OFF_INT_CTRL &&
      !reg_wdata[0] && diff == 4'h0 |=> !port_change_flag)
    else $error("change flag not cleared");
  wake_a:
    assert property (wake_req == port_change_flag) else $error("wake");
  dir_pin_a:
    assert property (reg_wr && reg_addr[7:0] == OFF_PORT_B_DIR |=> ##1
      pb_oe_n[5:0] == $past(reg_wdata[5:0], 2)) else $error("port b dir");
  pc_ovr_a:
    assert property ($past(rst_n) |-> (pc_oe_n & $past(periph_en)) ==
      $past(periph_dir & periph_en)) else $error("port c override");
  pc_drv_a:
    assert property ($past(rst_n) |-> (pc_out & $past(periph_en &
      ~periph_dir)) == $past(periph_dout & periph_en & ~periph_dir))
    else $error("port c peripheral drive");
  alt_in_a:
    assert property ($past(rst_n) |->
      {ssp_slave_sel_n, ext_int_in} == $past(pb_in[1:0]))
    else $error("alternate inputs");
  prog_clk_a:
    assert property ($past(rst_n) |-> prog_clk == $past(pb_in[6] & prog_mode))
    else $error("programming clock");
endmodule

bind gpb_ports gpb_ports_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pb_in(pb_in),
  .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pullup_en), .pc_out(pc_out),
  .pc_oe_n(pc_oe_n), .periph_en(periph_en), .periph_dir(periph_dir),
  .periph_dout(periph_dout), .ext_int_in(ext_int_in),
  .ssp_slave_sel_n(ssp_slave_sel_n), .prog_mode(prog_mode),
  .prog_clk(prog_clk), .port_change_flag(port_change_flag),
  .wake_req(wake_req)
);

// *** gpb_board.sv ***
// board model that resolves the port b and port c pin levels
`timescale 1ns/1ps
module gpb_board (
  // clock
  input  wire logic       mclk,
  // device drive
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe_n,
  input  wire logic [7:0] pb_pullup_en,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe_n,
  // external drivers
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_b_en,
  input  wire logic [7:0] ext_c,
  input  wire logic [7:0] ext_c_en,
  // resolved levels
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in
);
  logic [7:0] flt_q;
  // a floating line wanders every cycle so no stale level is trusted;
  // the case test lets the pattern start without a reset of its own
  always_ff @(posedge mclk) begin
    flt_q <= (flt_q === 8'h55) ? 8'hAA : 8'h55;
  end
  // device drive wins, then external drive, then pull-up, else wander
  assign pb_in = ~pb_oe_n & pb_out | pb_oe_n & (ext_b_en & ext_b |
    ~ext_b_en & (pb_pullup_en | flt_q));
  assign pc_in = ~pc_oe_n & pc_out | pc_oe_n & (ext_c_en & ext_c |
    ~ext_c_en & flt_q);
endmodule

// *** tb_gpb_ports.sv ***
// self-checking bench for the port b / port c gpio block
`timescale 1ns/1ps
module tb_gpb_ports
  import gpb_pkg::*;
;
  logic       mclk, rst_n, reg_wr, reg_rd, prog_mode, prog_dout, prog_drv;
  logic       flag, wake, an8, an9, prog_clk, lvd, prog_din;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pb_in, pb_out, pb_oe_n, pb_pull;
  logic [7:0] pc_in, pc_out, pc_oe_n, periph_en, periph_dir, periph_dout;
  logic [7:0] periph_din, ext_b, ext_b_en, ext_c;
  int         errors, n_checks;

  // device and board
  gpb_ports u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pull),
    .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
    .periph_en(periph_en), .periph_dir(periph_dir),
    .periph_dout(periph_dout), .periph_din(periph_din), .ext_int_in(),
    .ssp_slave_sel_n(), .analog_channel_eight_sel(an8),
    .analog_channel_nine_sel(an9), .low_voltage_detect_input(lvd),
    .prog_mode(prog_mode), .prog_data_out(prog_dout),
    .prog_data_drive(prog_drv), .prog_clk(prog_clk), .prog_data_in(prog_din),
    .port_change_flag(flag), .wake_req(wake)
  );
  gpb_board u_brd (
    .mclk(mclk), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pull),
    .pc_out(pc_out), .pc_oe_n(pc_oe_n), .ext_b(ext_b), .ext_b_en(ext_b_en),
    .ext_c(ext_c), .ext_c_en(8'hFF), .pb_in(pb_in), .pc_in(pc_in)
  );

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register bus: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge mclk);
  endtask

  // the flag is awaited on its own pin, never by reading port b
  task automatic wait_flag;
    int i;
    // look just after each edge, once the flag has settled
    for (i = 0; i < 4 && flag !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (flag !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic t_reset;
    #1 chk(pb_pull, 8'h00);
    chk(pb_oe_n, RST_DIR);
    chk({7'h00, an8}, 8'h01);
    rd(9'h181, RST_OPTION);
    rd(9'h086, RST_DIR);
    rd(9'h09F, RST_CONV_CFG);
    rd(9'h187, 8'h00);
    rd(9'h1FF, 8'h00);
  endtask

  task automatic t_pull;
    wr(9'h081, 8'h7F);
    wr(9'h186, 8'hF0);
    wr(9'h006, 8'hA5);
    wr(9'h09F, 8'h06);
    ext_b_en <= 8'hEF;
    repeat (2) @(posedge mclk);
    #1 chk(pb_pull, 8'hF0);
    chk(pb_out & 8'h0F, 8'h05);
    chk({6'h00, an9, an8}, 8'h00);
    rd(9'h006, 8'h15);
    wr(9'h081, 8'hFF);
    ext_b_en <= 8'hFF;
    @(posedge mclk);
    #1 chk(pb_pull, 8'h00);
  endtask

  task automatic t_change;
    wr(9'h086, 8'hEF);
    rd(9'h106, 8'h00);
    wr(9'h00C, 8'h00);
    #1 chk({7'h00, flag}, 8'h00);
    ext_b[5] <= 1'b1;
    wait_flag();
    #1 chk({6'h00, wake, flag}, 8'h03);
    wr(9'h10C, 8'h00);
    #1 chk({7'h00, flag}, 8'h01);
    rd(9'h006, 8'h20);
    wr(9'h00C, 8'h00);
    #1 chk({7'h00, flag}, 8'h00);
    ext_b[3] <= 1'b1;
    wr(9'h006, 8'h10);
    repeat (3) @(posedge mclk);
    #1 chk({7'h00, flag}, 8'h00);
    chk({7'h00, lvd}, 8'h01);
  endtask

  task automatic t_port_c_pin_data;
    wr(9'h007, 8'h3C);
    wr(9'h087, 8'h0F);
    ext_c       <= 8'h5A;
    periph_en   <= 8'h81;
    periph_dir  <= 8'h80;
    periph_dout <= 8'h01;
    repeat (2) @(posedge mclk);
    #1 chk(pc_oe_n, 8'h8E);
    chk(pc_out & 8'h71, 8'h31);
    rd(9'h007, 8'h3B);
    #1 chk(periph_din, 8'h3B);
    wr(9'h087, 8'h0F);
    periph_en <= 8'h00;
  endtask

  task automatic t_prog;
    ext_b[6]  <= 1'b1;
    prog_mode <= 1'b1;
    prog_drv  <= 1'b1;
    prog_dout <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(pb_oe_n & 8'hC0, 8'h40);
    chk({6'h00, prog_clk, pb_out[7]}, 8'h03);
    chk({7'h00, prog_din}, 8'h01);
    // loader lets go of pin 7, the board holds it low
    prog_drv  <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, prog_din, pb_oe_n[7]}, 8'h01);
    prog_mode <= 1'b0;
    @(posedge mclk);
  endtask

  // reset held two cycles, then the scenarios in turn
  initial begin
    errors      = 0;
    n_checks    = 0;
    rst_n       = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 9'h000;
    reg_wdata   = 8'h00;
    prog_mode   = 1'b0;
    prog_dout   = 1'b0;
    prog_drv    = 1'b0;
    periph_en   = 8'h00;
    periph_dir  = 8'h00;
    periph_dout = 8'h00;
    ext_b       = 8'h00;
    ext_b_en    = 8'hFF;
    ext_c       = 8'h00;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_pull();
    t_change();
    t_port_c_pin_data();
    t_prog();
    tally_and_finish();
  end
endmodule
